/* logic/rap_pkg.sv */
/*
  rap_pkg: shared constants and types for the rms and active power core.
  Assumes a 50 MHz system clock and converter samples arriving at 6.99 kSPS.
*/
package rap_pkg;

  // sample and accumulator widths
  localparam int SAMP_W = 24;
  localparam int ACC_W = 49;
  localparam int ROOT_ITER = 24;

  // register addresses, narrow (24-bit) and wide (32-bit) views
  localparam logic [11:0] ADDR_PWR_A = 12'h212;
  localparam logic [11:0] ADDR_PWR_B = 12'h213;
  localparam logic [11:0] ADDR_IRMS_A = 12'h21A;
  localparam logic [11:0] ADDR_IRMS_B = 12'h21B;
  localparam logic [11:0] ADDR_VOLTAGE_RMS = 12'h21C;
  localparam logic [11:0] ADDR_PWR_A_W = 12'h312;
  localparam logic [11:0] ADDR_PWR_B_W = 12'h313;
  localparam logic [11:0] ADDR_IRMS_A_W = 12'h31A;
  localparam logic [11:0] ADDR_IRMS_B_W = 12'h31B;
  localparam logic [11:0] ADDR_VOLTAGE_RMS_W = 12'h31C;
  localparam logic [11:0] ADDR_REF_SEL = 12'h800;

  // reference select field and reset (0 = internal reference)
  localparam int REF_EXT_BIT = 0;
  localparam logic [7:0] REF_SEL_RESET = 8'h00;

  // timing: sample rate and settling target
  localparam int SAMPLE_RATE_HZ = 6990;
  localparam int SETTLE_MS = 200;
  localparam int SETTLE_SAMPLES = SETTLE_MS * SAMPLE_RATE_HZ / 1000;

  // default filter shift: time constant 2**8 samples, five of them fit the settling time
  localparam int LPF_SHIFT_DEF = 8;

  // output scaling: full-scale sine (6.5e6 peak) gives 9032007 rms and 4862401 power
  localparam int RMS_GAIN_DEF = 32196;
  localparam int RMS_GAIN_SHIFT = 14;
  localparam int PWR_GAIN_DEF = 253080;
  localparam int PWR_GAIN_SHIFT = 40;

  typedef enum logic [3:0] {
    RAP_IDLE = 4'b0001,
    RAP_FILT = 4'b0010,
    RAP_ROOT = 4'b0100,
    RAP_SCALE = 4'b1000
  } rap_state_e;

  typedef struct packed {
    logic signed [SAMP_W-1:0] cur_a;
    logic signed [SAMP_W-1:0] cur_b;
    logic signed [SAMP_W-1:0] volt;
  } rap_samp_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } rap_req_s;

  typedef struct packed {
    logic [SAMP_W-1:0] irms_a;
    logic [SAMP_W-1:0] irms_b;
    logic [SAMP_W-1:0] voltage_rms;
    logic signed [SAMP_W-1:0] pwr_a;
    logic signed [SAMP_W-1:0] pwr_b;
  } rap_res_s;

endpackage

/* logic/rap_isqrt.sv */
/*
  rap_isqrt: bit-serial integer square root, one result bit per clock.
  Assumes start is a one-cycle pulse given only while the unit is idle.
*/
`timescale 1ns/1ps
`default_nettype none

module rap_isqrt (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // request
  input wire logic start,
  input wire logic [2*rap_pkg::SAMP_W-1:0] radicand,
  // answer
  output logic done,
  output logic [rap_pkg::SAMP_W-1:0] root
);
  import rap_pkg::*;

  typedef struct packed {
    logic busy;
    logic done;
    logic [4:0] cnt;
    logic [2*SAMP_W-1:0] op;
    logic [2*SAMP_W-1:0] rad;
    logic [SAMP_W+1:0] rem;
    logic [SAMP_W-1:0] root;
  } rap_sqrt_s;

  rap_sqrt_s q;
  rap_sqrt_s next_q;

  always_comb begin
    logic [SAMP_W+1:0] rem_sh;
    logic [SAMP_W+1:0] trial;
    rem_sh = '0;
    trial = '0;
    next_q = q;
    next_q.done = 1'b0;
    if (start && !q.busy) begin
      next_q.busy = 1'b1;
      next_q.cnt = '0;
      next_q.op = radicand;
      next_q.rad = radicand;
      next_q.rem = '0;
      next_q.root = '0;
    end else if (q.busy) begin
      // RQ6 digit-by-digit root
      rem_sh = {q.rem[SAMP_W-1:0], q.op[2*SAMP_W-1 -: 2]};
      trial = {q.root, 2'b01};
      next_q.op = {q.op[2*SAMP_W-3:0], 2'b00};
      if (rem_sh >= trial) begin
        next_q.rem = rem_sh - trial;
        next_q.root = {q.root[SAMP_W-2:0], 1'b1};
      end else begin
        next_q.rem = rem_sh;
        next_q.root = {q.root[SAMP_W-2:0], 1'b0};
      end
      next_q.cnt = 5'(q.cnt + 5'h01);
      if (q.cnt == 5'(ROOT_ITER - 1)) begin
        next_q.busy = 1'b0;
        next_q.done = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign done = q.done;
  assign root = q.root;

  property p_root_exact;
    @(posedge sys_clk) disable iff (!nrst)
    q.done |-> (({25'h0, q.root} * {25'h0, q.root}) <= {1'b0, q.rad}) &&
      (({25'h0, q.root} + 49'h1) * ({25'h0, q.root} + 49'h1) > {1'b0, q.rad});
  endproperty
  a_root_exact: assert property (p_root_exact) else $error("root not floor sqrt"); // RQ6

  property p_root_latency;
    @(posedge sys_clk) disable iff (!nrst)
    (start && !q.busy) |-> ##24 !q.done ##1 q.done;
  endproperty
  a_root_latency: assert property (p_root_latency) else $error("root latency wrong"); // RQ6

endmodule

`default_nettype wire

/* logic/rap_core.sv */
/*
  rap_core: rms and active power datapath with its result and reference registers.
  Assumes one sample triple per valid pulse, spaced well beyond 40 clocks,
  and a register port driven synchronously by the host interface logic.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RQ1 - take signed 24-bit samples of both currents and voltage at the sample rate
// RQ2 - after reset the internal reference is selected
// RQ3 - writing 1 to bit 0 of reference select picks the external reference
// RQ4 - all three rms values are computed together from the same sample
// RQ5 - rms results refresh every sample and settle in about 200 ms
// RQ6 - rms is square, low-pass filter, then square root
// RQ7 - rms covers fundamental and harmonics within the 1.23 kHz band
// RQ8 - current rms A and B are unsigned 24-bit in their own registers
// RQ9 - full-scale current input reads about 9032007
// RQ10 - voltage rms is unsigned 24-bit in its own register, refreshed each sample
// RQ11 - full-scale voltage input reads about 9032007
// RQ12 - host should read rms in step with zero crossings to hide ripple
// RQ13 - power is current times voltage, dc taken by a second low-pass filter
// RQ14 - power for channels A and B computed together, each in its register
// RQ15 - full-scale current and voltage give about 4862401 power
// RQ16 - power covers harmonics within the 1.23 kHz band
// RQ17 - both power registers refresh every sample
// RQ18 - reads return latest results and never disturb them
module rap_core #(
  parameter int LPF_SHIFT = rap_pkg::LPF_SHIFT_DEF,
  parameter int RMS_GAIN = rap_pkg::RMS_GAIN_DEF,
  parameter int PWR_GAIN = rap_pkg::PWR_GAIN_DEF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // converter samples
  input wire logic samp_valid,
  input wire rap_pkg::rap_samp_s samp,
  // register port
  input wire rap_pkg::rap_req_s req,
  output logic [31:0] rd_data,
  output logic rd_valid,
  // reference control
  output logic ext_ref_sel
);
  import rap_pkg::*;

  typedef struct packed {
    rap_state_e st;
    rap_samp_s smp;
    logic signed [ACC_W-1:0] f_ia;
    logic signed [ACC_W-1:0] f_ib;
    logic signed [ACC_W-1:0] f_v;
    logic signed [ACC_W-1:0] f_pa;
    logic signed [ACC_W-1:0] f_pb;
    logic root_go;
    rap_res_s res;
    logic [7:0] ref_sel;
    logic [31:0] rd_data;
    logic rd_valid;
  } rap_core_s;

  rap_core_s q;
  rap_core_s next_q;
  logic [2:0] root_done;
  logic [SAMP_W-1:0] root_val [3];
  logic [2*SAMP_W-1:0] root_in [3];

  function automatic logic signed [ACC_W-1:0] widen(input logic signed [SAMP_W-1:0] s);
    widen = ACC_W'(s);
  endfunction

  // one-pole low-pass; a shift instead of a multiplier keeps it cheap
  function automatic logic signed [ACC_W-1:0] lpf(input logic signed [ACC_W-1:0] acc,
                                                  input logic signed [ACC_W-1:0] x);
    logic signed [ACC_W:0] d;
    d = (ACC_W+1)'(x) - (ACC_W+1)'(acc);
    lpf = ACC_W'((ACC_W+1)'(acc) + (d >>> LPF_SHIFT));
  endfunction

  // RQ9 full-scale rms gain
  // RQ11 same gain for voltage
  function automatic logic [SAMP_W-1:0] rms_scale(input logic [SAMP_W-1:0] r);
    logic [39:0] p;
    p = 40'(r) * 40'(RMS_GAIN);
    p = p >> RMS_GAIN_SHIFT;
    rms_scale = (|p[39:SAMP_W]) ? 24'hFFFFFF : p[SAMP_W-1:0];
  endfunction

  // RQ15 full-scale power gain
  function automatic logic signed [SAMP_W-1:0] pwr_scale(input logic signed [ACC_W-1:0] a);
    logic signed [68:0] p;
    p = 69'(a) * 69'(PWR_GAIN);
    p = p >>> PWR_GAIN_SHIFT;
    if (p > 69'sh7FFFFF) begin
      pwr_scale = 24'h7FFFFF;
    end else if (p < -69'sh800000) begin
      pwr_scale = 24'h800000;
    end else begin
      pwr_scale = p[SAMP_W-1:0];
    end
  endfunction

  // RQ8 current rms views
  // RQ10 voltage rms views
  // RQ14 power register views
  function automatic logic [31:0] rd_mux(input logic [11:0] a, input rap_res_s r,
                                         input logic [7:0] rs);
    unique case (a)
      ADDR_PWR_A: rd_mux = {8'h00, r.pwr_a};
      ADDR_PWR_B: rd_mux = {8'h00, r.pwr_b};
      ADDR_IRMS_A: rd_mux = {8'h00, r.irms_a};
      ADDR_IRMS_B: rd_mux = {8'h00, r.irms_b};
      ADDR_VOLTAGE_RMS: rd_mux = {8'h00, r.voltage_rms};
      ADDR_PWR_A_W: rd_mux = {{8{r.pwr_a[SAMP_W-1]}}, r.pwr_a};
      ADDR_PWR_B_W: rd_mux = {{8{r.pwr_b[SAMP_W-1]}}, r.pwr_b};
      ADDR_IRMS_A_W: rd_mux = {8'h00, r.irms_a};
      ADDR_IRMS_B_W: rd_mux = {8'h00, r.irms_b};
      ADDR_VOLTAGE_RMS_W: rd_mux = {8'h00, r.voltage_rms};
      ADDR_REF_SEL: rd_mux = {24'h000000, rs};
      default: rd_mux = 32'h00000000;
    endcase
  endfunction

  // RQ4 three roots in parallel
  assign root_in[0] = q.f_ia[2*SAMP_W-1:0];
  assign root_in[1] = q.f_ib[2*SAMP_W-1:0];
  assign root_in[2] = q.f_v[2*SAMP_W-1:0];

  for (genvar g = 0; g < 3; g++) begin : g_root
    rap_isqrt u_root (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .start(q.root_go),
      .radicand(root_in[g]),
      .done(root_done[g]),
      .root(root_val[g])
    );
  end

  always_comb begin
    next_q = q;
    next_q.root_go = 1'b0;
    next_q.rd_valid = 1'b0;
    unique case (q.st)
      RAP_IDLE: begin
        // RQ1 capture sample triple
        if (samp_valid) begin
          next_q.smp = samp;
          next_q.st = RAP_FILT;
        end
      end
      RAP_FILT: begin
        // RQ6 square and filter
        // RQ7 harmonics kept, every sample
        next_q.f_ia = lpf(q.f_ia, widen(q.smp.cur_a) * widen(q.smp.cur_a));
        next_q.f_ib = lpf(q.f_ib, widen(q.smp.cur_b) * widen(q.smp.cur_b));
        next_q.f_v = lpf(q.f_v, widen(q.smp.volt) * widen(q.smp.volt));
        // RQ13 product then dc filter
        // RQ16 harmonics kept, every product
        next_q.f_pa = lpf(q.f_pa, widen(q.smp.cur_a) * widen(q.smp.volt));
        next_q.f_pb = lpf(q.f_pb, widen(q.smp.cur_b) * widen(q.smp.volt));
        next_q.root_go = 1'b1;
        next_q.st = RAP_ROOT;
      end
      RAP_ROOT: begin
        if (root_done[0]) begin
          next_q.st = RAP_SCALE;
        end
      end
      RAP_SCALE: begin
        // RQ5 refresh every sample
        next_q.res.irms_a = rms_scale(root_val[0]);
        next_q.res.irms_b = rms_scale(root_val[1]);
        next_q.res.voltage_rms = rms_scale(root_val[2]);
        // RQ17 power refresh
        next_q.res.pwr_a = pwr_scale(q.f_pa);
        next_q.res.pwr_b = pwr_scale(q.f_pb);
        next_q.st = RAP_IDLE;
      end
    endcase
    // RQ18 reads leave results alone
    if (req.rd) begin
      next_q.rd_data = rd_mux(req.addr, q.res, q.ref_sel);
      next_q.rd_valid = 1'b1;
    end
    // RQ3 reference select write
    if (req.wr && req.addr == ADDR_REF_SEL) begin
      next_q.ref_sel = req.wdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.st <= RAP_IDLE;
      // RQ2 internal reference
      q.ref_sel <= REF_SEL_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign rd_data = q.rd_data;
  assign rd_valid = q.rd_valid;
  assign ext_ref_sel = q.ref_sel[REF_EXT_BIT];

  property p_ref_hold;
    @(posedge sys_clk) disable iff (!nrst)
    !(req.wr && req.addr == ADDR_REF_SEL) |=> $stable(ext_ref_sel);
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("reference changed without write"); // RQ2

  property p_ref_write;
    @(posedge sys_clk) disable iff (!nrst)
    (req.wr && req.addr == ADDR_REF_SEL) |=> ext_ref_sel == $past(req.wdata[REF_EXT_BIT]);
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("reference write lost"); // RQ3

  property p_accept;
    @(posedge sys_clk) disable iff (!nrst)
    (samp_valid && q.st == RAP_IDLE) |=> q.st == RAP_FILT && q.smp == $past(samp);
  endproperty
  a_accept: assert property (p_accept) else $error("sample not captured"); // RQ1

  property p_refresh;
    @(posedge sys_clk) disable iff (!nrst)
    (samp_valid && q.st == RAP_IDLE) |-> ##28 q.st == RAP_SCALE ##1 q.st == RAP_IDLE;
  endproperty
  a_refresh: assert property (p_refresh) else $error("result refresh late"); // RQ5

  property p_roots_together;
    @(posedge sys_clk) disable iff (!nrst)
    root_done[0] |-> root_done[1] && root_done[2];
  endproperty
  a_roots_together: assert property (p_roots_together) else $error("roots out of step"); // RQ4

  property p_rd_no_effect;
    @(posedge sys_clk) disable iff (!nrst)
    (req.rd && q.st != RAP_SCALE) |=> $stable(q.res);
  endproperty
  a_rd_no_effect: assert property (p_rd_no_effect) else $error("read disturbed results"); // RQ18

  property p_irms_read;
    @(posedge sys_clk) disable iff (!nrst)
    (req.rd && req.addr == ADDR_IRMS_A) |=> rd_valid && rd_data == {8'h00, $past(q.res.irms_a)};
  endproperty
  a_irms_read: assert property (p_irms_read) else $error("current rms read wrong"); // RQ8

  property p_voltage_rms_read;
    @(posedge sys_clk) disable iff (!nrst)
    (req.rd && req.addr == ADDR_VOLTAGE_RMS_W) |=> rd_data == {8'h00, $past(q.res.voltage_rms)};
  endproperty
  a_voltage_rms_read: assert property (p_voltage_rms_read) else $error("voltage rms read wrong"); // RQ10

  property p_pwr_read;
    @(posedge sys_clk) disable iff (!nrst)
    (req.rd && req.addr == ADDR_PWR_B_W) |=>
      rd_data == {{8{$past(q.res.pwr_b[SAMP_W-1])}}, $past(q.res.pwr_b)};
  endproperty
  a_pwr_read: assert property (p_pwr_read) else $error("power read wrong"); // RQ14

  property p_irms_b_read;
    @(posedge sys_clk) disable iff (!nrst)
    (req.rd && req.addr == ADDR_IRMS_B_W) |=> rd_data == {8'h00, $past(q.res.irms_b)};
  endproperty
  a_irms_b_read: assert property (p_irms_b_read) else $error("rms b read wrong"); // RQ8

  property p_pwr_a_read;
    @(posedge sys_clk) disable iff (!nrst)
    (req.rd && req.addr == ADDR_PWR_A) |=> rd_data == {8'h00, $past(q.res.pwr_a)};
  endproperty
  a_pwr_a_read: assert property (p_pwr_a_read) else $error("narrow power read wrong"); // RQ14

  property p_res_hold;
    @(posedge sys_clk) disable iff (!nrst)
    q.st != RAP_SCALE |=> $stable(q.res);
  endproperty
  a_res_hold: assert property (p_res_hold) else $error("results moved between updates"); // RQ5

  property p_root_first;
    @(posedge sys_clk) disable iff (!nrst)
    q.st == RAP_SCALE |-> $past(root_done[0]);
  endproperty
  a_root_first: assert property (p_root_first) else $error("scaled before root"); // RQ6

  property p_rd_pulse;
    @(posedge sys_clk) disable iff (!nrst)
    !req.rd |=> !rd_valid;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read answer without request"); // RQ18

  c_sample: cover property (@(posedge sys_clk) disable iff (!nrst)
    q.st == RAP_SCALE);
  c_ext_ref: cover property (@(posedge sys_clk) disable iff (!nrst)
    $rose(ext_ref_sel));
  c_neg_power: cover property (@(posedge sys_clk) disable iff (!nrst)
    q.res.pwr_a[SAMP_W-1]);
  c_rd_during_update: cover property (@(posedge sys_clk) disable iff (!nrst)
    req.rd && q.st == RAP_SCALE);

endmodule

`default_nettype wire

/* verif/rap_adc_model.sv */
/*
  rap_adc_model: converter side, one signed sample triple every PERIOD clocks.
  Assumes the bench picks the dc level of each channel through lvl.
*/
`timescale 1ns/1ps
`default_nettype none

module rap_adc_model #(
  parameter int PERIOD = 64
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // levels chosen by the bench
  input wire rap_pkg::rap_samp_s lvl,
  // sample stream
  output logic samp_valid,
  output rap_pkg::rap_samp_s samp
);
  import rap_pkg::*;
  int cnt;
  always @(posedge sys_clk or negedge nrst) begin
    #1;
    if (!nrst) begin
      cnt = 0;
      samp_valid = 1'b0;
      samp = '0;
    end else begin
      cnt = (cnt == PERIOD - 1) ? 0 : cnt + 1;
      samp_valid = (cnt == 0);
      // unqualified cycles carry a toggling pattern, every other one repeating the last sample
      samp = samp_valid ? lvl : ~samp;
    end
  end
endmodule

`default_nettype wire

/* verif/rap_core_test.sv */
/*
  rap_core_test: register-level checks of the rms and power core.
  Assumes a fast filter (LPF_SHIFT 2) so dc levels settle in a few dozen samples.
*/
`timescale 1ns/1ps
`default_nettype none

module rap_core_test;
  import rap_pkg::*;
  localparam int PER = 64;
  logic sys_clk;
  logic nrst;
  logic samp_valid;
  rap_samp_s samp;
  rap_samp_s lvl;
  rap_req_s req;
  logic [31:0] rd_data;
  logic rd_valid;
  logic ext_ref_sel;
  logic [31:0] got;
  logic [31:0] got2;
  int error_cnt;
  int n_tests;
  real fs_dc;

  rap_core #(.LPF_SHIFT(2)) i_rap_core (.sys_clk(sys_clk), .nrst(nrst),
    .samp_valid(samp_valid), .samp(samp), .req(req), .rd_data(rd_data),
    .rd_valid(rd_valid), .ext_ref_sel(ext_ref_sel));
  rap_adc_model #(.PERIOD(PER)) i_rap_adc_model (.sys_clk(sys_clk), .nrst(nrst),
    .lvl(lvl), .samp_valid(samp_valid), .samp(samp));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic close_out;
    $display("error_cnt=%0d n_tests=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_eq(input logic [31:0] g, input logic [31:0] e, input string msg);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %0t %s got %h exp %h", $time, msg, g, e);
    end
  endtask

  task automatic chk_near(input logic [31:0] raw, input real g, input real e,
                          input string msg);
    real tol;
    tol = ((e < 0.0) ? -e : e) * 0.01 + 200.0;
    n_tests++;
    if ($isunknown(raw) || (g - e > tol) || (e - g > tol)) begin
      error_cnt++;
      $display("FAIL %0t %s got %0.0f exp %0.0f", $time, msg, g, e);
    end
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(posedge sys_clk);
    #1;
    req.wr = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  // idle cycle after each read keeps strobes from toggling in one step
  task automatic reg_rd(input logic [11:0] a, output logic [31:0] d);
    req.rd = 1'b1;
    req.addr = a;
    @(posedge sys_clk);
    #1;
    req.rd = 1'b0;
    chk_eq(32'(rd_valid), 32'h1, "read answer missing");
    d = rd_data;
    @(posedge sys_clk);
    #1;
  endtask

  // narrow view zero-padded, wide view sign- or zero-extended
  task automatic chk_res(input logic [11:0] a, input real e, input string msg);
    logic [31:0] d;
    reg_rd(a, d);
    chk_eq({24'h0, d[31:24]}, 32'h0, msg);
    chk_near(d, (e < 0.0) ? $itor($signed(d[23:0])) : $itor(d[23:0]), e, msg);
    reg_rd(a + 12'h100, d);
    chk_near(d, $itor($signed(d)), e, msg);
  endtask

  function automatic logic signed [23:0] lvl_of(input real f);
    return 24'($rtoi(fs_dc * f));
  endfunction

  // read only once settled, dc levels carry no ripple
  task automatic settle;
    repeat (60 * PER) @(posedge sys_clk);
    #1;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    $display("FAIL %0t watchdog expired", $time);
    close_out();
  end

  initial begin
    nrst = 1'b0;
    req = '0;
    lvl = '0;
    error_cnt = 0;
    n_tests = 0;
    fs_dc = 6500000.0 / $sqrt(2.0);
    repeat (8) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    chk_eq(32'(ext_ref_sel), 32'h0, "ref after reset");
    reg_rd(ADDR_REF_SEL, got);
    chk_eq(got, {24'h0, REF_SEL_RESET}, "ref reset value");
    reg_wr(ADDR_REF_SEL, 32'h1);
    chk_eq(32'(ext_ref_sel), 32'h1, "external ref");
    reg_rd(ADDR_REF_SEL, got);
    chk_eq(got, 32'h1, "ref readback");
    reg_wr(ADDR_REF_SEL, 32'hFE);
    chk_eq(32'(ext_ref_sel), 32'h0, "only bit 0 picks ref");
    reg_wr(ADDR_IRMS_A, 32'h123);
    reg_rd(ADDR_IRMS_A, got);
    chk_eq(got, 32'h0, "rms written");
    reg_rd(12'h7FF, got);
    chk_eq(got, 32'h0, "unmapped read");
    // full scale on every channel
    lvl = '{lvl_of(1.0), lvl_of(1.0), lvl_of(1.0)};
    settle();
    chk_res(ADDR_IRMS_A, 9032007.0, "irms a fs");
    chk_res(ADDR_IRMS_B, 9032007.0, "irms b fs");
    chk_res(ADDR_VOLTAGE_RMS, 9032007.0, "voltage_rms fs");
    chk_res(ADDR_PWR_A, 4862401.0, "pwr a fs");
    chk_res(ADDR_PWR_B, 4862401.0, "pwr b fs");
    reg_rd(ADDR_PWR_A, got);
    reg_rd(ADDR_PWR_A, got2);
    chk_eq(got2, got, "reread changed");
    // channels differ, one current reversed
    lvl = '{lvl_of(1.0), lvl_of(-0.5), lvl_of(0.5)};
    settle();
    chk_res(ADDR_IRMS_A, 9032007.0, "irms a mix");
    chk_res(ADDR_IRMS_B, 4516003.5, "irms b neg");
    chk_res(ADDR_VOLTAGE_RMS, 4516003.5, "voltage_rms half");
    chk_res(ADDR_PWR_A, 2431200.5, "pwr a mix");
    chk_res(ADDR_PWR_B, -1215600.25, "pwr b neg");
    // step: one or two updates move results part way only
    lvl.volt = lvl_of(1.0);
    repeat (PER + 31) @(posedge sys_clk);
    #1;
    reg_rd(ADDR_VOLTAGE_RMS, got);
    chk_eq(32'(got > 4600000 && got < 8900000), 32'h1, "voltage_rms refresh");
    reg_rd(ADDR_PWR_A, got);
    chk_eq(32'(got > 2450000 && got < 4800000), 32'h1, "pwr refresh");
    settle();
    chk_res(ADDR_VOLTAGE_RMS, 9032007.0, "voltage_rms settled");
    chk_res(ADDR_PWR_B, -2431200.5, "pwr b settled");
    close_out();
  end
endmodule

`default_nettype wire
